// *** avc_pkg.sv ***
// avc_pkg: constants, reset values and carrier types for the volume control block.
// assumes a 32-bit classic Wishbone register bus and a 40 MHz system clock.
package avc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register map: word index, byte address is four times the index
	localparam logic [5:0] AVC_IDX_ADC = 6'h01;
	localparam logic [5:0] AVC_IDX_DAC = 6'h02;
	localparam logic [5:0] AVC_IDX_BYP = 6'h03;
	localparam logic [5:0] AVC_IDX_RAMP = 6'h04;

	////////////////////////////////////////////////////////////////////////////
	// field layout inside each 16-bit register
	localparam int AVC_REG_W = 16;
	localparam int AVC_CODE_W = 7;
	localparam int AVC_HI_MUTE = 15;
	localparam int AVC_HI_LSB = 8;
	localparam int AVC_LO_MUTE = 7;
	localparam int AVC_LO_LSB = 0;
	localparam int AVC_RAMP_DONE_BIT = 0;
	localparam int AVC_RAMP_RATE_BIT = 1;

	////////////////////////////////////////////////////////////////////////////
	// reset values and writable masks
	localparam logic [15:0] AVC_RST_ADC = 16'hD700;
	localparam logic [15:0] AVC_RST_DAC = 16'hFFFF;
	localparam logic [15:0] AVC_RST_BYP = 16'hE7E7;
	localparam logic [15:0] AVC_RST_RAMP = 16'h0000;
	localparam logic [15:0] AVC_WMASK_ADC = 16'hFF00;
	localparam logic [15:0] AVC_WMASK_GAIN = 16'hFFFF;
	localparam logic [15:0] AVC_WMASK_RAMP = 16'h0002;

	////////////////////////////////////////////////////////////////////////////
	// lowest gain code of each stage, the point at which muting engages
	localparam logic [6:0] AVC_ADC_FLOOR = 7'h07;
	localparam logic [6:0] AVC_DAC_FLOOR = 7'h00;
	localparam logic [6:0] AVC_BYP_FLOOR = 7'h20;

	////////////////////////////////////////////////////////////////////////////
	// channel order on the gain output vector
	localparam int AVC_CH = 5;
	localparam int AVC_CH_ADC = 0;
	localparam int AVC_CH_DAC_L = 1;
	localparam int AVC_CH_DAC_R = 2;
	localparam int AVC_CH_BYP_L = 3;
	localparam int AVC_CH_BYP_R = 4;

	////////////////////////////////////////////////////////////////////////////
	// soft-step timing
	localparam int AVC_CLK_PERIOD_PS = 25000;
	localparam int AVC_STEP_NORMAL_US = 20;
	localparam int AVC_STEP_HALF_US = 40;
	localparam int AVC_STEP_NORMAL_CYC = AVC_STEP_NORMAL_US * 1000000 / AVC_CLK_PERIOD_PS;
	localparam int AVC_STEP_HALF_CYC = AVC_STEP_HALF_US * 1000000 / AVC_CLK_PERIOD_PS;
	localparam int AVC_CNT_W = 12;

	typedef struct packed {
		logic [6:0] gain;
		logic muted;
	} avc_chan_t;

endpackage : avc_pkg

// *** avc_regs.sv ***
// avc_regs: gain/mute register bank with soft-stepped applied gains.
// assumes a classic Wishbone master on clk_i and a synchronous active-high reset.
//
// Overview of operation
// - ADC input gain is a 7-bit code spanning -40 to +20 dB, half-dB steps.
// - ADC code 7Fh is +20 dB, 57h is 0 dB, 07h is -40 dB.
// - ADC codes below 07h mute the input with the same soft-stepped mute.
// - ADC mute bit ramps gain to floor then mutes; stored code kept for unmute.
// - Reset leaves ADC muted with gain code 57h.
// - ADC gain changes are always reached by gradual stepping.
// - Left and right DAC 7-bit gains, bits 14:8 and 6:0, -63.5 to 0 dB.
// - DAC code 7Fh is 0 dB, 00h is -63.5 dB, half dB per code.
// - Left DAC mute ramps gain down then sends zero samples; code kept.
// - Right DAC mute ramps gain down then sends zero samples; code kept.
// - Reset leaves both DAC channels muted with code 7Fh.
// - Left and right bypass 7-bit gains, bits 14:8 and 6:0, -35.5 to +12 dB.
// - Bypass code 7Fh is +12 dB, 67h is 0 dB, 20h is -35.5 dB; reset 67h.
// - Bypass codes below 20h mute that bypass channel.
// - Left bypass mute ramps gain to floor then mutes; clearing reverses it.
// - Right bypass mute ramps gain to floor then mutes; clearing reverses it.
// - Reset leaves both bypass paths muted.
// - Read-only done flag is 1 when all stepping finished; resets to 1.
// - One step every 20 us normally, every 40 us at half rate.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
module avc_regs
	import avc_pkg::*;
#(
	parameter int STEP_NORMAL_CYC = AVC_STEP_NORMAL_CYC,
	parameter int STEP_HALF_CYC = AVC_STEP_HALF_CYC
) (
	input wire logic clk_i, // system clock, 40 MHz
	input wire logic rst_i, // synchronous reset, active high
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write enable
	input wire logic [7:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte selects
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	output avc_chan_t [AVC_CH-1:0] chan_o, // applied gain and mute per stage
	output logic ramp_done_o // all stepping finished
);

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	logic [15:0] adc_r;
	logic [15:0] dac_r;
	logic [15:0] byp_r;
	logic [15:0] ramp_r;
	logic ack_r;
	logic [31:0] rdat_r;
	logic ramp_done_r;
	logic req;
	logic wr_go;
	logic [5:0] idx;
	logic mapped;
	logic [15:0] rd_nxt;

	assign req = wb_cyc_i & wb_stb_i;
	assign idx = wb_adr_i[7:2];
	assign wr_go = req & wb_we_i & ack_r;
	assign mapped = (idx == AVC_IDX_ADC) || (idx == AVC_IDX_DAC) ||
		(idx == AVC_IDX_BYP) || (idx == AVC_IDX_RAMP);

	function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] dat,
		input logic [3:0] sel, input logic [15:0] wmask);
		logic [15:0] m;
		m = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
		return (old & ~m) | (dat[15:0] & m);
	endfunction : wmerge

	always_comb begin
		case (idx)
			AVC_IDX_ADC: rd_nxt = adc_r & AVC_WMASK_ADC;
			AVC_IDX_DAC: rd_nxt = dac_r;
			AVC_IDX_BYP: rd_nxt = byp_r;
			AVC_IDX_RAMP: begin
				rd_nxt = ramp_r & AVC_WMASK_RAMP;
				rd_nxt[AVC_RAMP_DONE_BIT] = ramp_done_r;
			end
			default: rd_nxt = 16'h0000;
		endcase
	end

	// ack one cycle after the request, dropped in the following cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else if (ce_i) begin
			ack_r <= req & ~ack_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_r <= 32'h0000_0000;
		end else if (ce_i && req && !ack_r) begin
			rdat_r <= {16'h0000, rd_nxt};
		end
	end

	// masked by the enable: a frozen edge must never complete a transfer
	assign wb_ack_o = ack_r & ce_i;
	assign wb_dat_o = rdat_r;

	////////////////////////////////////////////////////////////////////////////
	// registers, written at the acknowledging edge

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adc_r <= AVC_RST_ADC;
			dac_r <= AVC_RST_DAC;
			byp_r <= AVC_RST_BYP;
			ramp_r <= AVC_RST_RAMP;
		end else if (ce_i && wr_go && mapped) begin
			case (idx)
				AVC_IDX_ADC: adc_r <= wmerge(adc_r, wb_dat_i, wb_sel_i, AVC_WMASK_ADC);
				AVC_IDX_DAC: dac_r <= wmerge(dac_r, wb_dat_i, wb_sel_i, AVC_WMASK_GAIN);
				AVC_IDX_BYP: byp_r <= wmerge(byp_r, wb_dat_i, wb_sel_i, AVC_WMASK_GAIN);
				AVC_IDX_RAMP: ramp_r <= wmerge(ramp_r, wb_dat_i, wb_sel_i, AVC_WMASK_RAMP);
				default: ramp_r <= ramp_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// step timer

	logic [AVC_CNT_W-1:0] cnt_r;
	logic [AVC_CNT_W-1:0] cnt_lim;
	logic tick;

	assign cnt_lim = ramp_r[AVC_RAMP_RATE_BIT] ? AVC_CNT_W'(STEP_HALF_CYC - 1) :
		AVC_CNT_W'(STEP_NORMAL_CYC - 1);
	assign tick = ce_i && (cnt_r >= cnt_lim);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= '0;
		end else if (ce_i) begin
			cnt_r <= (cnt_r >= cnt_lim) ? '0 : cnt_r + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-stage soft stepping

	logic [AVC_CH-1:0] mute_req;
	logic [6:0] code [AVC_CH];
	logic [6:0] gain_r [AVC_CH];
	logic [6:0] tgt [AVC_CH];
	logic [6:0] floor_c [AVC_CH];
	logic [AVC_CH-1:0] mute_eff;
	logic [AVC_CH-1:0] settled;

	assign mute_req[AVC_CH_ADC] = adc_r[AVC_HI_MUTE];
	assign code[AVC_CH_ADC] = adc_r[AVC_HI_LSB +: AVC_CODE_W];
	assign mute_req[AVC_CH_DAC_L] = dac_r[AVC_HI_MUTE];
	assign code[AVC_CH_DAC_L] = dac_r[AVC_HI_LSB +: AVC_CODE_W];
	assign mute_req[AVC_CH_DAC_R] = dac_r[AVC_LO_MUTE];
	assign code[AVC_CH_DAC_R] = dac_r[AVC_LO_LSB +: AVC_CODE_W];
	assign mute_req[AVC_CH_BYP_L] = byp_r[AVC_HI_MUTE];
	assign code[AVC_CH_BYP_L] = byp_r[AVC_HI_LSB +: AVC_CODE_W];
	assign mute_req[AVC_CH_BYP_R] = byp_r[AVC_LO_MUTE];
	assign code[AVC_CH_BYP_R] = byp_r[AVC_LO_LSB +: AVC_CODE_W];

	genvar g;
	generate
		for (g = 0; g < AVC_CH; g++) begin : g_ch
			localparam logic [6:0] FLOOR = (g == AVC_CH_ADC) ? AVC_ADC_FLOOR :
				(g <= AVC_CH_DAC_R) ? AVC_DAC_FLOOR : AVC_BYP_FLOOR;

			assign floor_c[g] = FLOOR;
			// codes below the floor behave as a mute request
			assign mute_eff[g] = mute_req[g] | (code[g] < FLOOR);
			// muting ramps to the floor, the stored code stays untouched
			assign tgt[g] = mute_eff[g] ? FLOOR : code[g];
			assign settled[g] = (gain_r[g] == tgt[g]);

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					gain_r[g] <= FLOOR;
				end else if (tick && !settled[g]) begin
					// one code per step, never overshooting the target
					gain_r[g] <= (gain_r[g] < tgt[g]) ? gain_r[g] + 7'h01 :
						gain_r[g] - 7'h01;
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					chan_o[g] <= '{gain: FLOOR, muted: 1'b1};
				end else if (ce_i) begin
					chan_o[g].gain <= gain_r[g];
					// mute only once the floor is reached
					chan_o[g].muted <= mute_eff[g] && (gain_r[g] == FLOOR);
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ramp_done_r <= 1'b1;
		end else if (ce_i) begin
			ramp_done_r <= &settled;
		end
	end

	assign ramp_done_o = ramp_done_r;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_adc_reset;
		$past(rst_i) |-> adc_r == AVC_RST_ADC && gain_r[AVC_CH_ADC] == AVC_ADC_FLOOR;
	endproperty
	a_adc_reset: assert property (p_adc_reset) else $error("adc reset value wrong");

	property p_dac_byp_reset;
		$past(rst_i) |-> dac_r == AVC_RST_DAC && byp_r == AVC_RST_BYP && ramp_done_r;
	endproperty
	a_dac_byp_reset: assert property (p_dac_byp_reset) else $error("gain reset wrong");

	property p_step_one;
		$changed(gain_r[AVC_CH_ADC]) |-> $past(tick) &&
			(gain_r[AVC_CH_ADC] == $past(gain_r[AVC_CH_ADC]) + 7'h01 ||
			gain_r[AVC_CH_ADC] == $past(gain_r[AVC_CH_ADC]) - 7'h01);
	endproperty
	a_step_one: assert property (p_step_one) else $error("adc gain jumped");

	property p_step_toward;
		tick && !settled[AVC_CH_DAC_L] && gain_r[AVC_CH_DAC_L] < tgt[AVC_CH_DAC_L] |=>
			gain_r[AVC_CH_DAC_L] == $past(gain_r[AVC_CH_DAC_L]) + 7'h01;
	endproperty
	a_step_toward: assert property (p_step_toward) else $error("dac step wrong");

	property p_mute_floor;
		chan_o[AVC_CH_DAC_R].muted |-> chan_o[AVC_CH_DAC_R].gain == AVC_DAC_FLOOR;
	endproperty
	a_mute_floor: assert property (p_mute_floor) else $error("muted above floor");

	property p_byp_low_code;
		ce_i && code[AVC_CH_BYP_L] < AVC_BYP_FLOOR && gain_r[AVC_CH_BYP_L] == AVC_BYP_FLOOR
			|=> chan_o[AVC_CH_BYP_L].muted;
	endproperty
	a_byp_low_code: assert property (p_byp_low_code) else $error("bypass not muted");

	property p_adc_low_code;
		ce_i && !mute_req[AVC_CH_ADC] && code[AVC_CH_ADC] < AVC_ADC_FLOOR && tick &&
			gain_r[AVC_CH_ADC] > AVC_ADC_FLOOR |=>
			gain_r[AVC_CH_ADC] == $past(gain_r[AVC_CH_ADC]) - 7'h01;
	endproperty
	a_adc_low_code: assert property (p_adc_low_code) else $error("adc not ramping down");

	property p_done_flag;
		ramp_done_o && $past(ce_i) |-> $past(&settled);
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("done flag while stepping");

	property p_tick_gap;
		tick |=> !tick [*8];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("steps too close");

	property p_rsv_read;
		wb_ack_o && !wb_we_i && wb_adr_i[7:2] == AVC_IDX_ADC |-> wb_dat_o[7:0] == 8'h00;
	endproperty
	a_rsv_read: assert property (p_rsv_read) else $error("reserved bits nonzero");

	property p_left_mute_kept;
		ce_i && mute_req[AVC_CH_BYP_L] && !(wr_go && idx == AVC_IDX_BYP)
			|=> $stable(code[AVC_CH_BYP_L]);
	endproperty
	a_left_mute_kept: assert property (p_left_mute_kept) else $error("stored code lost");

	// per-stage range, mute and freeze checks

	property p_adc_range;
		chan_o[AVC_CH_ADC].gain >= AVC_ADC_FLOOR;
	endproperty
	a_adc_range: assert property (p_adc_range) else $error("adc gain below floor");

	property p_adc_map;
		ce_i && settled[AVC_CH_ADC] && !mute_eff[AVC_CH_ADC]
			|=> chan_o[AVC_CH_ADC].gain == $past(code[AVC_CH_ADC]);
	endproperty
	a_adc_map: assert property (p_adc_map) else $error("adc gain not at code");

	property p_adc_mute_bit;
		ce_i && mute_req[AVC_CH_ADC] && gain_r[AVC_CH_ADC] == AVC_ADC_FLOOR
			|=> chan_o[AVC_CH_ADC].muted;
	endproperty
	a_adc_mute_bit: assert property (p_adc_mute_bit) else $error("adc not muted");

	property p_adc_down;
		tick && mute_req[AVC_CH_ADC] && gain_r[AVC_CH_ADC] > AVC_ADC_FLOOR
			|=> gain_r[AVC_CH_ADC] == $past(gain_r[AVC_CH_ADC]) - 7'h01;
	endproperty
	a_adc_down: assert property (p_adc_down) else $error("adc mute not ramping");

	property p_adc_unmute;
		ce_i && !mute_eff[AVC_CH_ADC] |=> !chan_o[AVC_CH_ADC].muted;
	endproperty
	a_adc_unmute: assert property (p_adc_unmute) else $error("adc still muted");

	property p_dac_left_zero;
		chan_o[AVC_CH_DAC_L].muted |-> chan_o[AVC_CH_DAC_L].gain == floor_c[AVC_CH_DAC_L];
	endproperty
	a_dac_left_zero: assert property (p_dac_left_zero) else $error("left dac zeroed early");

	property p_dac_right_map;
		ce_i && settled[AVC_CH_DAC_R] && !mute_eff[AVC_CH_DAC_R]
			|=> chan_o[AVC_CH_DAC_R].gain == $past(code[AVC_CH_DAC_R]);
	endproperty
	a_dac_right_map: assert property (p_dac_right_map) else $error("dac gain not at code");

	property p_code_sticky;
		ce_i && mute_req[AVC_CH_DAC_R] && !(wr_go && idx == AVC_IDX_DAC)
			|=> $stable(code[AVC_CH_DAC_R]);
	endproperty
	a_code_sticky: assert property (p_code_sticky) else $error("right code lost");

	property p_byp_range;
		gain_r[AVC_CH_BYP_L] >= floor_c[AVC_CH_BYP_L] &&
			gain_r[AVC_CH_BYP_R] >= floor_c[AVC_CH_BYP_R];
	endproperty
	a_byp_range: assert property (p_byp_range) else $error("bypass below floor");

	property p_byp_reset;
		$past(rst_i) |-> byp_r[AVC_HI_MUTE] && byp_r[AVC_LO_MUTE] &&
			chan_o[AVC_CH_BYP_L].muted && chan_o[AVC_CH_BYP_R].muted;
	endproperty
	a_byp_reset: assert property (p_byp_reset) else $error("bypass not muted at reset");

	property p_unmute_up;
		tick && !mute_eff[AVC_CH_BYP_L] && gain_r[AVC_CH_BYP_L] < code[AVC_CH_BYP_L]
			|=> gain_r[AVC_CH_BYP_L] == $past(gain_r[AVC_CH_BYP_L]) + 7'h01;
	endproperty
	a_unmute_up: assert property (p_unmute_up) else $error("bypass unmute not ramping");

	property p_byp_right_mute;
		tick && mute_req[AVC_CH_BYP_R] && gain_r[AVC_CH_BYP_R] > AVC_BYP_FLOOR
			|=> gain_r[AVC_CH_BYP_R] == $past(gain_r[AVC_CH_BYP_R]) - 7'h01;
	endproperty
	a_byp_right_mute: assert property (p_byp_right_mute) else $error("right bypass stuck");

	property p_rsv_write;
		ce_i && wr_go && idx == AVC_IDX_ADC |=> adc_r[AVC_HI_LSB-1:0] == 8'h00;
	endproperty
	a_rsv_write: assert property (p_rsv_write) else $error("reserved bits written");

	property p_done_low;
		ce_i && !(&settled) |=> !ramp_done_o;
	endproperty
	a_done_low: assert property (p_done_low) else $error("done flag high while stepping");

	property p_freeze;
		!ce_i |=> $stable(cnt_r) && $stable(chan_o) && $stable(ramp_done_o);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	c_adc_unmute: cover property (!mute_req[AVC_CH_ADC] && settled[AVC_CH_ADC] &&
		gain_r[AVC_CH_ADC] == code[AVC_CH_ADC]);
	c_half_rate: cover property (tick && ramp_r[AVC_RAMP_RATE_BIT]);
	c_done_rise: cover property ($rose(ramp_done_o));
	c_write_ack: cover property (wr_go && idx == AVC_IDX_DAC);
	c_ce_freeze: cover property (!ce_i && !settled[AVC_CH_DAC_L]);

endmodule : avc_regs

// *** avc_regs_bench.sv ***
// avc_regs_bench: self-checking bench for the volume control register bank.
// assumes avc_pkg and avc_regs are compiled first; short step counts are used.
`timescale 1ns/1ps
module avc_regs_bench
	import avc_pkg::*;
;
	localparam int SN = 10;
	localparam int SH = 20;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h00000000;
	logic [31:0] rdat;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic ramp_done_o;
	avc_chan_t [AVC_CH-1:0] chan_o;
	avc_chan_t [AVC_CH-1:0] hold;
	int num_errors = 0;
	int tests_run = 0;
	logic [15:0] tab [3][3] = '{'{16'h57FF, 16'h7F7F, 16'h6767},
		'{16'h06A5, 16'h8000, 16'h1F20}, '{16'h0700, 16'h00FF, 16'h7F9F}};
	logic [15:0] a, d, b;

	always #12.5 clk_i = ~clk_i;

	avc_regs #(.STEP_NORMAL_CYC(SN), .STEP_HALF_CYC(SH)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.chan_o(chan_o), .ramp_done_o(ramp_done_o));

	////////////////////////////////////////////////////////////////////////////
	task end_sim;
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task xfer(input logic w, input logic [7:0] ad, input logic [15:0] v, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		sel <= s;
		dat <= {16'h0000, v};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) chk(32'h0, 32'h1, "no ack");
		rdat = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : xfer

	task wr(input logic [7:0] ad, input logic [15:0] v);
		xfer(1'b1, ad, v, 4'hF);
	endtask : wr

	task rd(input logic [7:0] ad, input logic [31:0] exp);
		xfer(1'b0, ad, 16'h0000, 4'hF);
		chk(rdat, exp, "read");
	endtask : rd

	task wait_done;
		int n;
		repeat (2) @(posedge clk_i);
		n = 0;
		while (ramp_done_o !== 1'b1 && n < 6000) begin
			@(posedge clk_i);
			n++;
		end
		chk({31'h0, ramp_done_o}, 32'h1, "done");
	endtask : wait_done

	// settled gain and mute of one stage
	function automatic avc_chan_t ex(input logic [6:0] c, input logic m, input logic [6:0] f);
		ex.muted = m || (c < f);
		ex.gain = ex.muted ? f : c;
	endfunction : ex

	task chk_all;
		chk(chan_o[AVC_CH_ADC], ex(a[14:8], a[15], 7'h07), "adc");
		chk(chan_o[AVC_CH_DAC_L], ex(d[14:8], d[15], 7'h00), "dacl");
		chk(chan_o[AVC_CH_DAC_R], ex(d[6:0], d[7], 7'h00), "dacr");
		chk(chan_o[AVC_CH_BYP_L], ex(b[14:8], b[15], 7'h20), "bypl");
		chk(chan_o[AVC_CH_BYP_R], ex(b[6:0], b[7], 7'h20), "bypr");
		rd(8'h04, {16'h0000, a & 16'hFF00});
		rd(8'h08, {16'h0000, d});
		rd(8'h0C, {16'h0000, b});
	endtask : chk_all

	// times one step of the left dac channel and reads the flag while stepping
	task step_t(input int per, input logic r);
		int n;
		wr(8'h08, 16'h7F7F);
		wait_done;
		wr(8'h08, 16'h7C7C);
		n = 0;
		while (chan_o[AVC_CH_DAC_L].gain === 7'h7F && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		chk({25'h0, chan_o[AVC_CH_DAC_L].gain}, 32'h7E, "one code");
		n = 0;
		while (chan_o[AVC_CH_DAC_L].gain === 7'h7E && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		chk(n, per, "step period");
		rd(8'h10, {30'h0, r, 1'b0});
		wait_done;
	endtask : step_t

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk_i);
		num_errors++;
		end_sim;
	end

	initial begin
		void'($urandom(62));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		a = 16'hD700;
		d = 16'hFFFF;
		b = 16'hE7E7;
		@(posedge clk_i);
		chk({31'h0, ramp_done_o}, 32'h1, "done at reset");
		chk_all;
		rd(8'h10, 32'h1);
		rd(8'h00, 32'h0);
		rd(8'h14, 32'h0);
		for (int i = 0; i < 8; i++) begin
			a = (i < 3) ? tab[i][0] : 16'($urandom);
			d = (i < 3) ? tab[i][1] : 16'($urandom);
			b = (i < 3) ? tab[i][2] : 16'($urandom);
			wr(8'h04, a);
			wr(8'h08, d);
			wr(8'h0C, b);
			wait_done;
			chk_all;
		end
		xfer(1'b1, 8'h08, 16'hABCD, 4'h1);
		d = {d[15:8], 8'hCD};
		wr(8'h14, 16'hFFFF);
		wr(8'h00, 16'hFFFF);
		wait_done;
		chk_all;
		step_t(SN, 1'b0);
		wr(8'h10, 16'hFFFF);
		step_t(SH, 1'b1);
		rd(8'h10, 32'h3);
		// enable low in mid-ramp must hold both applied DAC gains and the flag
		d = 16'h0000;
		wr(8'h08, d);
		repeat (5 * SH) @(posedge clk_i);
		ce_i <= 1'b0;
		@(posedge clk_i);
		hold = chan_o;
		repeat (3 * SH) @(posedge clk_i);
		chk(chan_o[AVC_CH_DAC_L], hold[AVC_CH_DAC_L], "frozen dacl");
		chk(chan_o[AVC_CH_DAC_R], hold[AVC_CH_DAC_R], "frozen dacr");
		chk({31'h0, ramp_done_o}, 32'h0, "frozen done");
		ce_i <= 1'b1;
		wait_done;
		chk_all;
		end_sim;
	end
endmodule : avc_regs_bench
